/* File: bcce_pkg.sv */
// condition code evaluator package: register map, fields, types
// assumes one 40 MHz clock domain shared with the bc sequencer
package bcce_pkg;

	// register word addresses
	localparam logic [7:0] BCCE_ADDR_CFG = 8'h32;
	localparam logic [7:0] BCCE_ADDR_GPF = 8'h37;
	localparam logic [7:0] BCCE_ADDR_OUTC = 8'h40;
	localparam logic [7:0] BCCE_ADDR_ISTAT = 8'h41;
	localparam logic [7:0] BCCE_ADDR_IMASK = 8'h42;

	// reset values
	localparam logic [15:0] BCCE_CFG_RST = 16'h0000;
	localparam logic [7:0] BCCE_GPF_RST = 8'h00;
	localparam logic [3:0] BCCE_IMASK_RST = 4'h0;

	// configuration fields
	localparam int BCCE_CFG_TMO_HI = 15;
	localparam int BCCE_CFG_TMO_LO = 14;
	localparam int BCCE_CFG_BCAST_EN = 0;

	// condition code field
	localparam int BCCE_CC_INV = 4;
	localparam logic [3:0] BCCE_CC_NOREPLY = 4'h8;
	localparam logic [3:0] BCCE_CC_FMT = 4'h9;
	localparam logic [3:0] BCCE_CC_BLOCK = 4'hA;
	localparam logic [3:0] BCCE_CC_MSKSTAT = 4'hB;
	localparam logic [3:0] BCCE_CC_FAULTY = 4'hC;
	localparam logic [3:0] BCCE_CC_RETRY1 = 4'hD;
	localparam logic [3:0] BCCE_CC_RETRY2 = 4'hE;
	localparam logic [3:0] BCCE_CC_ALWAYS = 4'hF;

	// message control word fields
	localparam int BCCE_CW_MSG_ERR = 14;
	localparam int BCCE_CW_SVC_REQ = 13;
	localparam int BCCE_CW_BUSY = 12;
	localparam int BCCE_CW_SUBSYS = 11;
	localparam int BCCE_CW_TERM = 10;
	localparam int BCCE_CW_RSVD = 9;
	localparam int BCCE_CW_BCAST = 5;

	// received status word fields
	localparam int BCCE_SW_ADDR_HI = 15;
	localparam int BCCE_SW_ADDR_LO = 11;
	localparam int BCCE_SW_MSG_ERR = 10;
	localparam int BCCE_SW_SVC_REQ = 8;
	localparam int BCCE_SW_RSVD_HI = 7;
	localparam int BCCE_SW_RSVD_LO = 5;
	localparam int BCCE_SW_BCAST = 4;
	localparam int BCCE_SW_BUSY = 3;
	localparam int BCCE_SW_SUBSYS = 2;
	localparam int BCCE_SW_TERM = 0;

	// interrupt status bit positions
	localparam int BCCE_IRQ_DONE = 0;
	localparam int BCCE_IRQ_FAULTY = 1;
	localparam int BCCE_IRQ_MSKSTAT = 2;
	localparam int BCCE_IRQ_SKIP = 3;

	// message kinds reported at completion
	typedef enum logic [2:0] {
		BCCE_MSG_BC_RT = 3'h0,
		BCCE_MSG_RT_BC = 3'h1,
		BCCE_MSG_RT_RT = 3'h2,
		BCCE_MSG_MODE_TX_DATA = 3'h3,
		BCCE_MSG_MODE_RX_DATA = 3'h4,
		BCCE_MSG_MODE_NO_DATA = 3'h5
	} bcce_msg_kind_t;

	// message outcome from the protocol engine
	typedef struct packed {
		bcce_msg_kind_t kind;
		logic reply_seen;
		logic [7:0] reply_delay_us;
		logic sync_err;
		logic enc_err;
		logic bitcnt_err;
		logic parity_err;
		logic wcnt_err;
		logic loopback_err;
		logic status_valid;
		logic [15:0] status_word;
		logic [4:0] cmd_addr;
		logic [15:0] ctrl_word;
		logic [1:0] retries;
	} bcce_msg_result_t;

	// latched outcome flags of the last message
	typedef struct packed {
		logic [1:0] retries;
		logic faulty_message_flag;
		logic masked_status_flag;
		logic clean_block_flag;
		logic format_fault_flag;
		logic no_reply_flag;
	} bcce_outcome_t;

	// flag manipulation op: both bits set toggles
	typedef struct packed {
		logic [7:0] set_bits;
		logic [7:0] clr_bits;
	} bcce_flag_op_t;

endpackage

/* File: bcce_condition_eval.sv */
// condition code evaluator for the bus controller sequencer
// assumes the sequencer, protocol engine and host port share clk_sys_in
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps

// Function
// - codes 0 to 7 test user flags; host writes them at 0x0037
// - code 8 tests no reply or reply later than selected timeout
// - code 9 tests format fault from sync, encoding, bits, parity, count
// - status word address not matching command also sets format fault
// - clean block set after error-free rt-bc, rt-rt or transmit mode data
// - clean block cleared after invalid, bc-rt, receive mode or no-data mode
// - masked status set when unmasked control bit 14-10 matches set status
// - reserved mask low sets masked status on any reserved status bit
// - broadcast enable, control bit 5 low and status bit 4 sets it
// - code C tests faulty message: format, no reply or loopback
// - masked status never affects the faulty message flag
// - code D true on one or more retries, inverse on no retry
// - code E true on two retries; inverse is undefined
// - code F plain always evaluates true
// - code F inverse always evaluates false, a no-op
// - user flags set, cleared or toggled by op or host write
// - instruction executes only on true; otherwise pointer skips ahead
module bcce_condition_eval #(
	parameter logic [31:0] REPLY_LIMIT_US = 32'h80402010 // four timeout choices
) (
	input wire logic clk_sys_in, // 40 MHz system clock
	input wire logic rst_in, // async reset, high
	input wire logic [7:0] addr_in, // register word address
	input wire logic [15:0] wr_data_in, // write data
	input wire logic wr_en_in, // write strobe
	input wire logic rd_en_in, // read strobe
	output logic [15:0] rd_data_out, // read data, cycle after strobe
	input wire logic msg_done_in, // message completed pulse
	input wire bcce_pkg::bcce_msg_result_t msg_res_in, // outcome of message
	input wire logic flag_op_in, // flag manipulate op pulse
	input wire bcce_pkg::bcce_flag_op_t flag_arg_in, // op argument
	input wire logic eval_req_in, // evaluate condition pulse
	input wire logic [4:0] cond_in, // condition field
	input wire logic uncond_in, // op code ignores condition
	output logic eval_done_out, // evaluation answer pulse
	output logic eval_true_out, // condition result
	output logic exec_out, // instruction executes
	output logic skip_out, // pointer advances past it
	output logic [7:0] user_flags_out, // user flag register
	output bcce_pkg::bcce_outcome_t outcome_out, // last message flags
	output logic irq_out // level interrupt
);
	import bcce_pkg::*;

	////////////////////////////////////////////////////////////////
	// state

	logic [15:0] cfg_q;
	logic [7:0] gpf_q;
	logic [7:0] gpf_d;
	bcce_outcome_t outc_q;
	bcce_outcome_t outc_d;
	logic [3:0] istat_q;
	logic [3:0] imask_q;
	logic [3:0] irq_evt;
	logic host_gpf_wr;
	logic [7:0] host_set;
	logic [7:0] host_clr;
	logic cond_val;
	logic [7:0] reply_limit;
	logic [4:0] sw_addr;
	logic [4:0] cw_mask_hit;
	logic rsvd_hit;
	logic bcast_hit;
	logic valid_err;

	////////////////////////////////////////////////////////////////
	// user flags

	// set, clear, or toggle when both are asked
	function automatic logic [7:0] flag_apply(
		input logic [7:0] cur,
		input logic [7:0] s,
		input logic [7:0] c
	);
		flag_apply = (cur & ~c & ~s) | (s & ~c) | (s & c & ~cur)
			| (cur & ~s & ~c);
	endfunction

	// host word: low byte sets, high byte clears
	assign host_gpf_wr = wr_en_in && (addr_in == BCCE_ADDR_GPF);
	assign host_set = host_gpf_wr ? wr_data_in[7:0] : 8'h00;
	assign host_clr = host_gpf_wr ? wr_data_in[15:8] : 8'h00;

	// op applied first, host write on top of it
	always_comb begin
		gpf_d = gpf_q;
		if (flag_op_in) begin
			gpf_d = flag_apply(gpf_d, flag_arg_in.set_bits,
				flag_arg_in.clr_bits);
		end
		gpf_d = flag_apply(gpf_d, host_set, host_clr);
	end

	// user flag register
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			gpf_q <= BCCE_GPF_RST;
		end else begin
			gpf_q <= gpf_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// configuration register

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			cfg_q <= BCCE_CFG_RST;
		end else if (wr_en_in && addr_in == BCCE_ADDR_CFG) begin
			cfg_q <= wr_data_in;
		end
	end

	////////////////////////////////////////////////////////////////
	// message outcome

	// timeout picked by configuration bits 15-14
	always_comb begin
		unique case (cfg_q[BCCE_CFG_TMO_HI:BCCE_CFG_TMO_LO])
			2'b00: reply_limit = REPLY_LIMIT_US[7:0];
			2'b01: reply_limit = REPLY_LIMIT_US[15:8];
			2'b10: reply_limit = REPLY_LIMIT_US[23:16];
			2'b11: reply_limit = REPLY_LIMIT_US[31:24];
		endcase
	end

	assign sw_addr = msg_res_in.status_word[BCCE_SW_ADDR_HI:BCCE_SW_ADDR_LO];

	assign valid_err = msg_res_in.sync_err | msg_res_in.enc_err
		| msg_res_in.bitcnt_err | msg_res_in.parity_err
		| msg_res_in.wcnt_err;

	// a zero mask bit lets the status bit through
	assign cw_mask_hit = ~msg_res_in.ctrl_word[BCCE_CW_MSG_ERR:BCCE_CW_TERM]
		& {msg_res_in.status_word[BCCE_SW_MSG_ERR],
		msg_res_in.status_word[BCCE_SW_SVC_REQ],
		msg_res_in.status_word[BCCE_SW_BUSY],
		msg_res_in.status_word[BCCE_SW_SUBSYS],
		msg_res_in.status_word[BCCE_SW_TERM]};

	assign rsvd_hit = !msg_res_in.ctrl_word[BCCE_CW_RSVD]
		&& (|msg_res_in.status_word[BCCE_SW_RSVD_HI:BCCE_SW_RSVD_LO]);

	assign bcast_hit = cfg_q[BCCE_CFG_BCAST_EN]
		&& !msg_res_in.ctrl_word[BCCE_CW_BCAST]
		&& msg_res_in.status_word[BCCE_SW_BCAST];

	// next outcome, taken only at message completion
	always_comb begin
		outc_d.no_reply_flag = !msg_res_in.reply_seen
			|| (msg_res_in.reply_delay_us > reply_limit);
		outc_d.format_fault_flag = valid_err
			|| (msg_res_in.status_valid
			&& sw_addr != msg_res_in.cmd_addr);
		// status-mask outcome kept apart from fault logic
		outc_d.masked_status_flag = msg_res_in.status_valid
			&& ((|cw_mask_hit) || rsvd_hit || bcast_hit);
		outc_d.faulty_message_flag = outc_d.format_fault_flag
			|| outc_d.no_reply_flag
			|| msg_res_in.loopback_err;
		outc_d.clean_block_flag = 1'b0;
		if (!outc_d.faulty_message_flag) begin
			unique case (msg_res_in.kind)
				BCCE_MSG_RT_BC,
				BCCE_MSG_RT_RT,
				BCCE_MSG_MODE_TX_DATA: outc_d.clean_block_flag = 1'b1;
				default: outc_d.clean_block_flag = 1'b0;
			endcase
		end
		outc_d.retries = msg_res_in.retries;
	end

	// flags hold between completions
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			outc_q <= '0;
		end else if (msg_done_in) begin
			outc_q <= outc_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// condition evaluation

	// inverse bit flips each flag test
	always_comb begin
		cond_val = 1'b0;
		unique case (cond_in[3:0])
			4'h6, 4'h7,
			4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5:
				cond_val = gpf_q[cond_in[2:0]] ^ cond_in[BCCE_CC_INV];
			BCCE_CC_NOREPLY:
				cond_val = outc_q.no_reply_flag ^ cond_in[BCCE_CC_INV];
			BCCE_CC_FMT:
				cond_val = outc_q.format_fault_flag ^ cond_in[BCCE_CC_INV];
			BCCE_CC_BLOCK:
				cond_val = outc_q.clean_block_flag ^ cond_in[BCCE_CC_INV];
			BCCE_CC_MSKSTAT:
				cond_val = outc_q.masked_status_flag ^ cond_in[BCCE_CC_INV];
			BCCE_CC_FAULTY:
				cond_val = outc_q.faulty_message_flag ^ cond_in[BCCE_CC_INV];
			BCCE_CC_RETRY1:
				cond_val = cond_in[BCCE_CC_INV] ? (outc_q.retries == 2'h0)
					: (outc_q.retries != 2'h0);
			// undefined inverse is read as false, a safe skip
			BCCE_CC_RETRY2:
				cond_val = !cond_in[BCCE_CC_INV]
					&& (outc_q.retries == 2'h2);
			BCCE_CC_ALWAYS:
				cond_val = !cond_in[BCCE_CC_INV];
		endcase
	end

	// answer one cycle after the request
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			eval_done_out <= 1'b0;
			eval_true_out <= 1'b0;
			exec_out <= 1'b0;
			skip_out <= 1'b0;
		end else begin
			eval_done_out <= eval_req_in;
			if (eval_req_in) begin
				eval_true_out <= cond_val || uncond_in;
			end
			exec_out <= eval_req_in && (cond_val || uncond_in);
			skip_out <= eval_req_in && !(cond_val || uncond_in);
		end
	end

	////////////////////////////////////////////////////////////////
	// interrupts

	assign irq_evt[BCCE_IRQ_DONE] = msg_done_in;
	assign irq_evt[BCCE_IRQ_FAULTY] = msg_done_in && outc_d.faulty_message_flag;
	assign irq_evt[BCCE_IRQ_MSKSTAT] = msg_done_in && outc_d.masked_status_flag;
	assign irq_evt[BCCE_IRQ_SKIP] = eval_req_in && !(cond_val || uncond_in);

	// read clears, but a same-cycle event survives
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			istat_q <= 4'h0;
		end else if (rd_en_in && addr_in == BCCE_ADDR_ISTAT) begin
			istat_q <= irq_evt;
		end else begin
			istat_q <= istat_q | irq_evt;
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			imask_q <= BCCE_IMASK_RST;
		end else if (wr_en_in && addr_in == BCCE_ADDR_IMASK) begin
			imask_q <= wr_data_in[3:0];
		end
	end

	// lags status by one cycle to stay a clean flop output
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(istat_q & imask_q);
		end
	end

	////////////////////////////////////////////////////////////////
	// register read port

	// data valid only in the cycle after the strobe
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			rd_data_out <= 16'h0000;
		end else if (rd_en_in) begin
			unique case (addr_in)
				BCCE_ADDR_CFG: rd_data_out <= cfg_q;
				BCCE_ADDR_GPF: rd_data_out <= {8'h00, gpf_q};
				BCCE_ADDR_OUTC: rd_data_out <= {9'h000, outc_q};
				BCCE_ADDR_ISTAT: rd_data_out <= {12'h000, istat_q};
				BCCE_ADDR_IMASK: rd_data_out <= {12'h000, imask_q};
				default: rd_data_out <= 16'h0000;
			endcase
		end else begin
			rd_data_out <= 16'h0000;
		end
	end

	// mirrors for the sequencer and status pins
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			user_flags_out <= BCCE_GPF_RST;
			outcome_out <= '0;
		end else begin
			user_flags_out <= gpf_d;
			outcome_out <= msg_done_in ? outc_d : outc_q;
		end
	end

	////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);

	property p_host_set_six;
		host_gpf_wr && !flag_op_in && wr_data_in[6] && !wr_data_in[14]
			|=> user_flags_out[6] ##0 gpf_q[6];
	endproperty
	a_host_set_six: assert property (p_host_set_six)
		else $error("host set of flag six lost");

	property p_toggle;
		flag_op_in && !host_gpf_wr && flag_arg_in.set_bits[7]
			&& flag_arg_in.clr_bits[7] |=> gpf_q[7] != $past(gpf_q[7]);
	endproperty
	a_toggle: assert property (p_toggle)
		else $error("flag toggle failed");

	property p_no_reply;
		msg_done_in && !msg_res_in.reply_seen
			|=> outc_q.no_reply_flag && outc_q.faulty_message_flag;
	endproperty
	a_no_reply: assert property (p_no_reply)
		else $error("missing reply not flagged");

	property p_addr_mismatch;
		msg_done_in && msg_res_in.status_valid && sw_addr != msg_res_in.cmd_addr
			|=> outc_q.format_fault_flag;
	endproperty
	a_addr_mismatch: assert property (p_addr_mismatch)
		else $error("address mismatch not flagged");

	property p_block_clear;
		msg_done_in && msg_res_in.kind == BCCE_MSG_BC_RT
			|=> !outc_q.clean_block_flag;
	endproperty
	a_block_clear: assert property (p_block_clear)
		else $error("clean block kept after bc-rt");

	property p_mask_only;
		msg_done_in && !valid_err && !msg_res_in.loopback_err
			&& msg_res_in.reply_seen && msg_res_in.reply_delay_us <= reply_limit
			&& sw_addr == msg_res_in.cmd_addr
			|=> !outc_q.faulty_message_flag;
	endproperty
	a_mask_only: assert property (p_mask_only)
		else $error("faulty set without a fault");

	property p_always;
		eval_req_in && cond_in == 5'h0F |=> eval_true_out && exec_out;
	endproperty
	a_always: assert property (p_always)
		else $error("always code not true");

	property p_never;
		eval_req_in && cond_in == 5'h1F && !uncond_in
			|=> !eval_true_out && skip_out && !exec_out;
	endproperty
	a_never: assert property (p_never)
		else $error("never code executed");

	property p_one_answer;
		eval_req_in |=> eval_done_out && (exec_out != skip_out);
	endproperty
	a_one_answer: assert property (p_one_answer)
		else $error("exec and skip not exclusive");

	property p_retry;
		!msg_done_in && outc_q.retries == 2'h0 && eval_req_in
			&& cond_in == 5'h0D && !uncond_in |=> skip_out;
	endproperty
	a_retry: assert property (p_retry)
		else $error("retry test true with no retry");

	property p_hold;
		!msg_done_in |=> $stable(outc_q);
	endproperty
	a_hold: assert property (p_hold)
		else $error("outcome changed between messages");

	c_skip: cover property (eval_req_in ##1 skip_out);
	c_masked: cover property (msg_done_in ##1 outc_q.masked_status_flag);
	c_irq: cover property (msg_done_in ##[1:3] irq_out);

endmodule

/* File: bcce_rt_model.sv */
// remote terminal side model: reports one message outcome per request
// assumes the bench supplies the outcome and the reply latency in cycles
`timescale 1ns/100ps
module bcce_rt_model (
	input wire logic clk_sys_in, // system clock
	input wire logic rst_in, // async reset, high
	input wire logic go_in, // start one message
	input wire logic [3:0] lat_in, // cycles until completion
	input wire bcce_pkg::bcce_msg_result_t plan_in, // outcome to report
	output logic msg_done_out, // completion pulse
	output bcce_pkg::bcce_msg_result_t msg_res_out // reported outcome
);
	import bcce_pkg::*;
	logic [3:0] cnt_q;
	logic busy_q;
	bcce_msg_result_t hold_q;
	////////////////////////////////////////////////////////////////
	// outcome is only meaningful with the pulse; it churns otherwise
	// so a design sampling at the wrong edge sees garbage
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			busy_q <= 1'b0;
			cnt_q <= 4'h0;
			hold_q <= '0;
			msg_done_out <= 1'b0;
			msg_res_out <= '0;
		end else begin
			msg_done_out <= 1'b0;
			msg_res_out <= ~msg_res_out;
			if (go_in) begin
				busy_q <= 1'b1;
				cnt_q <= lat_in;
				hold_q <= plan_in;
			end else if (busy_q && cnt_q == 4'h0) begin
				busy_q <= 1'b0;
				msg_done_out <= 1'b1;
				msg_res_out <= hold_q;
				// silent terminal: no status word was captured
				if (!hold_q.reply_seen) begin
					msg_res_out.status_valid <= 1'b0;
					msg_res_out.status_word <= ~hold_q.status_word;
				end
			end else if (busy_q) begin
				cnt_q <= cnt_q - 4'h1;
			end
		end
	end
endmodule

/* File: bc_condition_code_eval_test.sv */
// self-checking bench for the condition code evaluator
// assumes one 40 MHz clock; message outcomes come from the terminal model
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
	$display("unexpected %s: expected %0h seen %0h", nm, e, g); end end
module bc_condition_code_eval_test;
	import bcce_pkg::*;
	localparam logic [31:0] LIMITS = 32'h80402010;
	logic clk_sys_in = 1'b0, rst_in = 1'b1, wr_en_in = 1'b0, rd_en_in = 1'b0;
	logic [7:0] addr_in = 8'h00;
	logic [15:0] wr_data_in = 16'h0000;
	logic flag_op_in = 1'b0, eval_req_in = 1'b0, uncond_in = 1'b0, go = 1'b0, slow = 1'b0;
	bcce_flag_op_t flag_arg_in = '0;
	logic [4:0] cond_in = 5'h00;
	logic [3:0] lat = 4'h0;
	bcce_msg_result_t plan = '0, msg_res_in;
	logic msg_done_in, eval_done_out, eval_true_out, exec_out, skip_out, irq_out;
	logic [15:0] rd_data_out;
	logic [7:0] user_flags_out;
	bcce_outcome_t outcome_out;
	int num_errors = 0, n_tests = 0;
	////////////////////////////////////////////////////////////////
	bcce_condition_eval #(.REPLY_LIMIT_US(LIMITS)) dut_u (.clk_sys_in(clk_sys_in),
		.rst_in(rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in),
		.rd_en_in(rd_en_in), .rd_data_out(rd_data_out), .msg_done_in(msg_done_in),
		.msg_res_in(msg_res_in), .flag_op_in(flag_op_in), .flag_arg_in(flag_arg_in),
		.eval_req_in(eval_req_in), .cond_in(cond_in), .uncond_in(uncond_in),
		.eval_done_out(eval_done_out), .eval_true_out(eval_true_out), .exec_out(exec_out),
		.skip_out(skip_out), .user_flags_out(user_flags_out), .outcome_out(outcome_out),
		.irq_out(irq_out));
	bcce_rt_model rt_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .go_in(go), .lat_in(lat),
		.plan_in(plan), .msg_done_out(msg_done_in), .msg_res_out(msg_res_in));
	// free running system clock
	initial begin
		forever #12.5 clk_sys_in = ~clk_sys_in;
	end
	////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// host port: one-cycle strobes, read data only in the next cycle
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys_in);
		wr_en_in <= 1'b1;
		addr_in <= a;
		wr_data_in <= d;
		@(posedge clk_sys_in);
		wr_en_in <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk_sys_in);
		rd_en_in <= 1'b1;
		addr_in <= a;
		@(posedge clk_sys_in);
		rd_en_in <= 1'b0;
		#1;
		`CHK("rd_data", e, rd_data_out)
	endtask
	// expected truth of a condition field, worked out from the flags
	function automatic logic cexp(input logic [4:0] c, input bcce_outcome_t o, input logic [7:0] f);
		logic r;
		case (c[3:0])
			4'h8: r = o.no_reply_flag;
			4'h9: r = o.format_fault_flag;
			4'hA: r = o.clean_block_flag;
			4'hB: r = o.masked_status_flag;
			4'hC: r = o.faulty_message_flag;
			4'hD: r = o.retries != 2'h0;
			4'hE: r = o.retries == 2'h2;
			4'hF: r = 1'b1;
			default: r = f[c[2:0]];
		endcase
		if (c == 5'h1E) return 1'b0;
		return c[4] ? ~r : r;
	endfunction
	task automatic ev(input logic [4:0] c, input logic u, input logic e);
		@(posedge clk_sys_in);
		eval_req_in <= 1'b1;
		cond_in <= c;
		uncond_in <= u;
		@(posedge clk_sys_in);
		eval_req_in <= 1'b0;
		#1;
		`CHK("eval_done", 1'b1, eval_done_out)
		`CHK("eval_true", e, eval_true_out)
		`CHK("exec", e, exec_out)
		`CHK("skip", ~e, skip_out)
	endtask
	// one message, then every outcome test in both senses
	task automatic m(input bcce_msg_kind_t k, input logic rep, input logic [7:0] dly,
		input logic [5:0] er, input logic [15:0] sw, input logic [15:0] cw,
		input logic [1:0] rt, input logic [6:0] e);
		int i;
		@(posedge clk_sys_in);
		go <= 1'b1;
		lat <= slow ? 4'h9 : 4'h0;
		slow <= ~slow;
		plan <= '{k, rep, dly, er[5], er[4], er[3], er[2], er[1], er[0], rep, sw, 5'h05, cw, rt};
		@(posedge clk_sys_in);
		go <= 1'b0;
		for (i = 0; i < 40 && msg_done_in !== 1'b1; i++) @(posedge clk_sys_in);
		if (i == 40) begin
			num_errors++;
			tally_and_finish();
		end
		#1;
		`CHK("outcome", e, outcome_out)
		for (i = 0; i < 14; i++) ev({i[0], 4'h8 + i[4:1]}, 1'b0, cexp({i[0], 4'h8 + i[4:1]}, e, 8'h00));
		`CHK("outcome_hold", e, outcome_out)
	endtask
	task automatic fop(input logic [7:0] s, input logic [7:0] c, input logic [7:0] e);
		@(posedge clk_sys_in);
		flag_op_in <= 1'b1;
		flag_arg_in <= '{s, c};
		@(posedge clk_sys_in);
		flag_op_in <= 1'b0;
		#1;
		`CHK("user_flags", e, user_flags_out)
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		#1;
		`CHK("irq_rst", 1'b0, irq_out)
		rd(BCCE_ADDR_CFG, BCCE_CFG_RST);
		rd(BCCE_ADDR_GPF, {8'h00, BCCE_GPF_RST});
		rd(BCCE_ADDR_IMASK, {12'h000, BCCE_IMASK_RST});
		rd(8'h55, 16'h0000);
		$display("test reset done");
		// user flags from host writes and from the flag op
		wr(BCCE_ADDR_GPF, 16'h00C0);
		`CHK("user_flags", 8'hC0, user_flags_out)
		ev(5'h06, 1'b0, 1'b1);
		ev(5'h07, 1'b0, 1'b1);
		ev(5'h16, 1'b0, 1'b0);
		wr(BCCE_ADDR_GPF, 16'h4000);
		wr(BCCE_ADDR_GPF, 16'h8080);
		rd(BCCE_ADDR_GPF, 16'h0000);
		ev(5'h17, 1'b0, 1'b1);
		fop(8'h41, 8'h00, 8'h41);
		fop(8'h83, 8'hC3, 8'h82);
		ev(5'h06, 1'b0, 1'b0);
		ev(5'h07, 1'b0, 1'b1);
		ev(5'h0F, 1'b0, 1'b1);
		ev(5'h1F, 1'b0, 1'b0);
		ev(5'h1F, 1'b1, 1'b1);
		$display("test flags done");
		// message outcomes, mask bits all set unless a case clears one
		m(BCCE_MSG_RT_BC, 1, 8'd4, 6'h00, 16'h2800, 16'h7E20, 2'h0, 7'h04);
		m(BCCE_MSG_BC_RT, 1, 8'd4, 6'h00, 16'h2800, 16'h7E20, 2'h0, 7'h00);
		m(BCCE_MSG_RT_BC, 0, 8'd4, 6'h00, 16'h2800, 16'h7E20, 2'h0, 7'h11);
		m(BCCE_MSG_RT_BC, 1, 8'd20, 6'h00, 16'h2800, 16'h7E20, 2'h0, 7'h11);
		m(BCCE_MSG_RT_BC, 1, 8'd4, 6'h04, 16'h2800, 16'h7E20, 2'h0, 7'h12);
		m(BCCE_MSG_RT_BC, 1, 8'd4, 6'h00, 16'h3000, 16'h7E20, 2'h0, 7'h12);
		m(BCCE_MSG_BC_RT, 1, 8'd4, 6'h01, 16'h2800, 16'h7E20, 2'h0, 7'h10);
		m(BCCE_MSG_BC_RT, 1, 8'd4, 6'h00, 16'h2900, 16'h5E20, 2'h0, 7'h08);
		m(BCCE_MSG_BC_RT, 1, 8'd4, 6'h00, 16'h2840, 16'h7C20, 2'h0, 7'h08);
		m(BCCE_MSG_BC_RT, 1, 8'd4, 6'h00, 16'h2810, 16'h7E00, 2'h0, 7'h00);
		wr(BCCE_ADDR_CFG, 16'h0001);
		m(BCCE_MSG_BC_RT, 1, 8'd4, 6'h00, 16'h2810, 16'h7E00, 2'h0, 7'h08);
		m(BCCE_MSG_RT_RT, 1, 8'd4, 6'h00, 16'h2800, 16'h7E20, 2'h1, 7'h24);
		m(BCCE_MSG_MODE_TX_DATA, 1, 8'd4, 6'h00, 16'h2800, 16'h7E20, 2'h2, 7'h44);
		m(BCCE_MSG_MODE_RX_DATA, 1, 8'd4, 6'h00, 16'h2800, 16'h7E20, 2'h0, 7'h00);
		m(BCCE_MSG_MODE_NO_DATA, 1, 8'd4, 6'h00, 16'h2800, 16'h7E20, 2'h0, 7'h00);
		wr(BCCE_ADDR_CFG, 16'h4000);
		m(BCCE_MSG_RT_BC, 1, 8'd20, 6'h00, 16'h2800, 16'h7E20, LIMITS[15:8] > 8'd20, 7'h04 | {LIMITS[15:8] > 8'd20, 5'h00});
		// the two longest timeout choices, one delay under its limit and one over it
		wr(BCCE_ADDR_CFG, 16'h8000);
		m(BCCE_MSG_RT_BC, 1, 8'd50, 6'h00, 16'h2800, 16'h7E20, 2'h0, 7'h04);
		wr(BCCE_ADDR_CFG, 16'hC000);
		m(BCCE_MSG_RT_BC, 1, 8'd200, 6'h00, 16'h2800, 16'h7E20, 2'h0, 7'h11);
		$display("test outcomes done");
		// interrupts: sticky status cleared by read, masked level output
		`CHK("irq_masked", 1'b0, irq_out)
		rd(BCCE_ADDR_ISTAT, 16'h000F);
		rd(BCCE_ADDR_ISTAT, 16'h0000);
		wr(BCCE_ADDR_IMASK, 16'h0002);
		m(BCCE_MSG_RT_BC, 1, 8'd4, 6'h00, 16'h2800, 16'h7E20, 2'h0, 7'h04);
		`CHK("irq_clean", 1'b0, irq_out)
		m(BCCE_MSG_RT_BC, 0, 8'd4, 6'h00, 16'h2800, 16'h7E20, 2'h0, 7'h11);
		`CHK("irq_faulty", 1'b1, irq_out)
		rd(BCCE_ADDR_ISTAT, 16'h000B);
		@(posedge clk_sys_in);
		#1;
		`CHK("irq_cleared", 1'b0, irq_out)
		wr(BCCE_ADDR_IMASK, 16'h0008);
		ev(5'h1F, 1'b0, 1'b0);
		@(posedge clk_sys_in);
		#1;
		`CHK("irq_skip", 1'b1, irq_out)
		rd(BCCE_ADDR_IMASK, 16'h0008);
		wr(BCCE_ADDR_OUTC, 16'hFFFF);
		rd(BCCE_ADDR_OUTC, 16'h0011);
		$display("test interrupts done");
		tally_and_finish();
	end
	// hang guard
	initial begin
		repeat (60000) @(posedge clk_sys_in);
		num_errors++;
		tally_and_finish();
	end
endmodule
